// file: design/spfp_pkg.sv
// Package for the serial flash slave port: opcodes, status layout,
// cycle timing and shared types.
// Assumes a 40 MHz system clock.
`default_nettype none

package spfp_pkg;

    // Opcodes, most significant bit first on the wire
    localparam logic [7:0] OPC_LATCH_SET = 8'h06;
    localparam logic [7:0] OPC_LATCH_CLR = 8'h04;
    localparam logic [7:0] OPC_STAT_RD   = 8'h05;
    localparam logic [7:0] OPC_STAT_WR   = 8'h01;
    localparam logic [7:0] OPC_ARR_RD    = 8'h03;
    localparam logic [7:0] OPC_ARR_WR    = 8'h02;
    localparam logic [7:0] OPC_SECT_ERA  = 8'h20;
    localparam logic [7:0] OPC_FULL_WIPE = 8'h60;

    // Status bit positions and reset value
    localparam int         ST_PROT_HI   = 3;
    localparam int         ST_PROT_LO   = 2;
    localparam int         ST_PERMIT    = 1;
    localparam int         ST_BUSY      = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Array geometry
    localparam int ARR_WORDS   = 512;
    localparam int SECT_WORDS  = 256;
    localparam int ARR_AW      = 9;
    localparam int BASIC_DW    = 8;
    localparam int EXT_DW      = 16;
    localparam int FIFO_DEPTH  = 8;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    // Internal cycle times, longest figures rounded down
    localparam int CLK_NS        = 25;
    localparam int WRITE_US      = 110;
    localparam int SECT_ERA_MS   = 501;
    localparam int FULL_ERA_MS   = 1002;
    localparam int WRITE_CYC     = WRITE_US * 1000 / CLK_NS;
    localparam int SECT_ERA_CYC  = SECT_ERA_MS * 1000000 / CLK_NS;
    localparam int FULL_ERA_CYC  = FULL_ERA_MS * 1000000 / CLK_NS;

    typedef enum logic [1:0] {PK_NONE, PK_WRITE, PK_SECT, PK_FULL} spfp_pend_t;

    typedef enum {
        ST_IDLE, ST_OPC, ST_ADDR, ST_RDATA, ST_STAT,
        ST_WDATA, ST_SWR, ST_WAIT, ST_IGNORE
    } spfp_state_t;

    typedef struct packed {
        logic [3:0] unused;
        logic       protectLevelHi;
        logic       protectLevelLo;
        logic       writePermit;
        logic       busyFlag;
    } spfp_status_t;

endpackage

`default_nettype wire

// file: design/spfp_port.sv
// Serial slave port onto the user flash array, plus its read FIFO.
// Assumes the serial pins are asynchronous to clk and that the master
// clocks no faster than about a fifth of clk.
`default_nettype none

module spfp_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         flush,
    // Fill side
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    // Drain side
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0]  wrPtr_r;
    logic [AW:0]  rdPtr_r;
    logic [AW:0]  count;

    assign count    = wrPtr_r - rdPtr_r;
    assign inReady  = count != (AW+1)'(DEPTH);
    assign outValid = count != '0;
    assign outData  = mem_r[rdPtr_r[AW-1:0]];

    always_ff @(posedge clk) begin
        if (inValid && inReady) begin
            mem_r[wrPtr_r[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || flush) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            if (inValid && inReady) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (outValid && outReady) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
        end
    end

    property p_fifo_bound;
        @(posedge clk) disable iff (rst) count <= (AW+1)'(DEPTH);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count past depth");
endmodule

module spfp_port #(
    parameter bit          EXTENDED  = 1'b1,
    parameter bit          READ_ONLY = 1'b0,
    parameter int unsigned WRITE_CYC = spfp_pkg::WRITE_CYC,
    parameter int unsigned SECT_CYC  = spfp_pkg::SECT_ERA_CYC,
    parameter int unsigned FULL_CYC  = spfp_pkg::FULL_ERA_CYC,
    parameter int          FDEPTH    = spfp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Serial pins
    input  wire logic sck,
    input  wire logic chipSelectN,
    input  wire logic serialIn,
    output logic      serialOut,
    output logic      serialOutEn
);
    localparam int         DW      = EXTENDED ? spfp_pkg::EXT_DW : spfp_pkg::BASIC_DW;
    localparam logic [4:0] DW_LAST = 5'(DW - 1);

    logic [2:0]           sckSync_r;
    logic [2:0]           csSync_r;
    logic [1:0]           siSync_r;
    logic                 sckRise;
    logic                 sckFall;
    logic                 csActive;
    logic                 csRise;
    logic                 siBit;
    spfp_pkg::spfp_state_t state_r;
    spfp_pkg::spfp_state_t opcNext;
    spfp_pkg::spfp_state_t addrNext;
    spfp_pkg::spfp_pend_t  pend_r;
    spfp_pkg::spfp_status_t status;
    logic [4:0]           bitCnt_r;
    logic [15:0]          rxSh_r;
    logic [15:0]          rxNext;
    logic [7:0]           opc_r;
    logic [8:0]           addrIn;
    logic [8:0]           pendAddr_r;
    logic [15:0]          pendData_r;
    logic                 opcDone;
    logic                 addrDone;
    logic                 wen_r;
    logic [1:0]           bp_r;
    logic [31:0]          busyCnt_r;
    logic                 busy;
    logic                 doWrite;
    logic                 doErase;
    logic                 eraseHi;
    logic [15:0]          flashMem_r [spfp_pkg::ARR_WORDS];
    logic [8:0]           rdPtr_r;
    logic                 fetchOn_r;
    logic                 fifoInReady;
    logic                 fifoOutValid;
    logic                 fifoPop;
    logic [15:0]          fifoOut;
    logic [15:0]          txSh_r;
    logic [15:0]          txWord;
    logic [4:0]           txCnt_r;
    logic                 soOut_r;
    logic                 soOe_r;

    // The second stage of each synchroniser feeds logic; the third stage of sck and select also feeds edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            sckSync_r <= 3'b000;
            csSync_r  <= 3'b111;
            siSync_r  <= 2'b00;
        end else begin
            sckSync_r <= {sckSync_r[1:0], sck};
            csSync_r  <= {csSync_r[1:0], chipSelectN};
            siSync_r  <= {siSync_r[0], serialIn};
        end
    end

    assign csActive = ~csSync_r[1];
    assign csRise   = csSync_r[1] & ~csSync_r[2];
    assign sckRise  = csActive & sckSync_r[1] & ~sckSync_r[2];
    assign sckFall  = csActive & ~sckSync_r[1] & sckSync_r[2];
    assign siBit    = siSync_r[1];
    assign rxNext   = {rxSh_r[14:0], siBit};
    assign opcDone  = sckRise && state_r == spfp_pkg::ST_OPC && bitCnt_r == 5'd7;
    assign addrDone = sckRise && state_r == spfp_pkg::ST_ADDR && bitCnt_r == DW_LAST;
    assign addrIn   = EXTENDED ? rxNext[8:0] : {1'b0, rxNext[7:0]};
    assign busy     = busyCnt_r != '0;

    always_comb begin
        status                = spfp_pkg::STATUS_RESET;
        status.protectLevelHi = bp_r[1];
        status.protectLevelLo = bp_r[0];
        status.writePermit    = wen_r;
        status.busyFlag       = busy;
    end

    function automatic logic isProt(input logic [8:0] a, input logic [1:0] bp);
        logic [1:0] top;
        top = EXTENDED ? a[8:7] : a[7:6];
        return bp == 2'd3 || (bp == 2'd2 && top[1]) || (bp == 2'd1 && top == 2'd3);
    endfunction

    // During a cycle only the status read is honoured
    always_comb begin
        opcNext = spfp_pkg::ST_IGNORE;
        if (rxNext[7:0] == spfp_pkg::OPC_STAT_RD && !READ_ONLY) begin
            opcNext = spfp_pkg::ST_STAT;
        end else if (!busy) begin
            unique case (rxNext[7:0])
                spfp_pkg::OPC_ARR_RD:    opcNext = spfp_pkg::ST_ADDR;
                spfp_pkg::OPC_LATCH_SET,
                spfp_pkg::OPC_LATCH_CLR,
                spfp_pkg::OPC_FULL_WIPE: begin
                    opcNext = READ_ONLY ? spfp_pkg::ST_IGNORE : spfp_pkg::ST_WAIT;
                end
                spfp_pkg::OPC_STAT_WR: begin
                    opcNext = READ_ONLY ? spfp_pkg::ST_IGNORE : spfp_pkg::ST_SWR;
                end
                spfp_pkg::OPC_ARR_WR: begin
                    opcNext = READ_ONLY ? spfp_pkg::ST_IGNORE : spfp_pkg::ST_ADDR;
                end
                spfp_pkg::OPC_SECT_ERA: begin
                    if (READ_ONLY) begin
                        opcNext = spfp_pkg::ST_IGNORE;
                    end else begin
                        opcNext = EXTENDED ? spfp_pkg::ST_ADDR : spfp_pkg::ST_WAIT;
                    end
                end
                default: opcNext = spfp_pkg::ST_IGNORE;
            endcase
        end
    end

    always_comb begin
        addrNext = spfp_pkg::ST_WAIT;
        if (opc_r == spfp_pkg::OPC_ARR_RD) begin
            addrNext = spfp_pkg::ST_RDATA;
        end else if (opc_r == spfp_pkg::OPC_ARR_WR) begin
            addrNext = (wen_r && !isProt(addrIn, bp_r)) ? spfp_pkg::ST_WDATA
                                                        : spfp_pkg::ST_IGNORE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !csActive) begin
            state_r  <= spfp_pkg::ST_IDLE;
            bitCnt_r <= '0;
        end else if (state_r == spfp_pkg::ST_IDLE) begin
            state_r  <= spfp_pkg::ST_OPC;
            bitCnt_r <= '0;
        end else if (sckRise) begin
            bitCnt_r <= bitCnt_r + 5'd1;
            if (opcDone) begin
                state_r  <= opcNext;
                bitCnt_r <= '0;
            end else if (addrDone) begin
                state_r  <= addrNext;
                bitCnt_r <= '0;
            end else if (state_r == spfp_pkg::ST_WDATA && bitCnt_r == DW_LAST) begin
                state_r <= spfp_pkg::ST_WAIT;
            end else if (state_r == spfp_pkg::ST_SWR && bitCnt_r == 5'd7) begin
                state_r <= spfp_pkg::ST_WAIT;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || state_r == spfp_pkg::ST_IDLE) begin
            rxSh_r <= '0;
            opc_r  <= '0;
        end else if (sckRise) begin
            rxSh_r <= rxNext;
            if (opcDone) begin
                opc_r <= rxNext[7:0];
            end
        end
    end

    // Status register; frozen during a cycle since only reads pass then
    always_ff @(posedge clk) begin
        if (rst) begin
            wen_r <= 1'b0;
            bp_r  <= 2'b00;
        end else if (opcDone && opcNext == spfp_pkg::ST_WAIT) begin
            if (rxNext[7:0] == spfp_pkg::OPC_LATCH_SET) begin
                wen_r <= 1'b1;
            end else if (rxNext[7:0] == spfp_pkg::OPC_LATCH_CLR) begin
                wen_r <= 1'b0;
            end
        end else if (sckRise && state_r == spfp_pkg::ST_SWR && bitCnt_r == 5'd7) begin
            bp_r <= {rxNext[spfp_pkg::ST_PROT_HI], rxNext[spfp_pkg::ST_PROT_LO]};
        end
    end

    // Array changes run only once select has risen
    always_ff @(posedge clk) begin
        if (rst || (state_r == spfp_pkg::ST_IDLE && csActive) || csRise) begin
            pend_r <= spfp_pkg::PK_NONE;
        end else if (opcDone && opcNext == spfp_pkg::ST_WAIT) begin
            pendAddr_r <= '0;
            if (rxNext[7:0] == spfp_pkg::OPC_FULL_WIPE) begin
                pend_r <= spfp_pkg::PK_FULL;
            end else if (rxNext[7:0] == spfp_pkg::OPC_SECT_ERA) begin
                pend_r <= spfp_pkg::PK_SECT;
            end
        end else if (addrDone) begin
            pendAddr_r <= addrIn;
            if (opc_r == spfp_pkg::OPC_SECT_ERA) begin
                pend_r <= spfp_pkg::PK_SECT;
            end
        end else if (sckRise && state_r == spfp_pkg::ST_WDATA && bitCnt_r == DW_LAST) begin
            pend_r     <= spfp_pkg::PK_WRITE;
            pendData_r <= rxNext;
        end
    end

    assign eraseHi = EXTENDED && (pend_r == spfp_pkg::PK_FULL || pendAddr_r[8]);
    assign doWrite = csRise && !busy && pend_r == spfp_pkg::PK_WRITE;
    assign doErase = csRise && !busy && wen_r
                     && ((pend_r == spfp_pkg::PK_SECT && (eraseHi ? bp_r == 2'd0 : bp_r != 2'd3))
                     || (pend_r == spfp_pkg::PK_FULL && bp_r == 2'd0));

    always_ff @(posedge clk) begin
        if (rst) begin
            busyCnt_r <= '0;
        end else if (doWrite) begin
            busyCnt_r <= 32'(WRITE_CYC);
        end else if (doErase) begin
            busyCnt_r <= (pend_r == spfp_pkg::PK_FULL && EXTENDED) ? 32'(FULL_CYC)
                                                                  : 32'(SECT_CYC);
        end else if (busy) begin
            busyCnt_r <= busyCnt_r - 32'd1;
        end
    end

    // Basic mode keeps its bytes in the low half of sector-0 words
    always_ff @(posedge clk) begin
        if (doWrite) begin
            flashMem_r[pendAddr_r][DW-1:0] <= pendData_r[DW-1:0];
        end else if (doErase) begin
            for (int i = 0; i < spfp_pkg::ARR_WORDS; i++) begin
                if ((i < spfp_pkg::SECT_WORDS) != eraseHi
                    || pend_r == spfp_pkg::PK_FULL && EXTENDED) begin
                    flashMem_r[i] <= spfp_pkg::ERASED_WORD;
                end
            end
        end
    end

    // Read prefetch; the FIFO absorbs the array ahead of the shifter
    always_ff @(posedge clk) begin
        if (rst || !csActive) begin
            fetchOn_r <= 1'b0;
            rdPtr_r   <= '0;
        end else if (addrDone && opc_r == spfp_pkg::OPC_ARR_RD) begin
            fetchOn_r <= 1'b1;
            rdPtr_r   <= addrIn;
        end else if (fetchOn_r && fifoInReady) begin
            rdPtr_r <= rdPtr_r + 9'd1;
            if (!EXTENDED && rdPtr_r == 9'd255) begin
                fetchOn_r <= 1'b0;
            end
        end
    end

    spfp_fifo #(
        .W     (16),
        .DEPTH (FDEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .flush    (!csActive),
        .inValid  (fetchOn_r),
        .inReady  (fifoInReady),
        .inData   (flashMem_r[rdPtr_r]),
        .outValid (fifoOutValid),
        .outReady (fifoPop),
        .outData  (fifoOut)
    );

    assign fifoPop = sckFall && state_r == spfp_pkg::ST_RDATA && txCnt_r == '0;
    assign txWord  = state_r == spfp_pkg::ST_STAT ? {status, 8'h00}
                   : EXTENDED ? fifoOut : {fifoOut[7:0], 8'h00};

    always_ff @(posedge clk) begin
        if (rst || !csActive) begin
            soOe_r  <= 1'b0;
            soOut_r <= 1'b0;
            txCnt_r <= '0;
            txSh_r  <= '0;
        end else if (sckFall && (state_r == spfp_pkg::ST_STAT
                                 || state_r == spfp_pkg::ST_RDATA)) begin
            if (txCnt_r != '0) begin
                soOut_r <= txSh_r[15];
                txSh_r  <= {txSh_r[14:0], 1'b0};
                txCnt_r <= txCnt_r - 5'd1;
            end else if (state_r == spfp_pkg::ST_STAT || fifoOutValid) begin
                soOe_r  <= 1'b1;
                soOut_r <= txWord[15];
                txSh_r  <= {txWord[14:0], 1'b0};
                txCnt_r <= state_r == spfp_pkg::ST_STAT ? 5'd7 : DW_LAST;
            end else begin
                soOe_r <= 1'b0;
            end
        end
    end

    assign serialOut   = soOut_r;
    assign serialOutEn = soOe_r & csActive;

    sequence s_opc_seen(logic [7:0] code);
        opcDone && rxNext[7:0] == code;
    endsequence

    property p_out_hiz;
        @(posedge clk) disable iff (rst) !csActive |-> !serialOutEn ##1 !soOe_r;
    endproperty
    a_out_hiz: assert property (p_out_hiz) else $error("output driven while deselected");

    property p_out_on_fall;
        @(posedge clk) disable iff (rst)
        csActive && $past(csActive) && $changed(soOut_r) |-> $past(sckFall);
    endproperty
    a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off a fall");

    property p_rx_on_rise;
        @(posedge clk) disable iff (rst)
        state_r != spfp_pkg::ST_IDLE && $changed(rxSh_r) |-> $past(sckRise);
    endproperty
    a_rx_on_rise: assert property (p_rx_on_rise) else $error("input shifted off a rise");

    property p_bad_opc;
        @(posedge clk) disable iff (rst)
        opcDone && opcNext == spfp_pkg::ST_IGNORE ##1 csActive
        |-> state_r == spfp_pkg::ST_IGNORE;
    endproperty
    a_bad_opc: assert property (p_bad_opc) else $error("bad opcode not ignored");

    property p_latch_set;
        @(posedge clk) disable iff (rst)
        s_opc_seen(spfp_pkg::OPC_LATCH_SET) ##0 !busy && !READ_ONLY |=> wen_r;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch set missed");

    property p_read_busy;
        @(posedge clk) disable iff (rst)
        s_opc_seen(spfp_pkg::OPC_ARR_RD) ##0 busy |=> !fetchOn_r [*4];
    endproperty
    a_read_busy: assert property (p_read_busy) else $error("read served while busy");

    property p_busy_start;
        @(posedge clk) disable iff (rst) $rose(busy) |-> $past(csRise);
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("cycle began off select rise");

    property p_stat_wr;
        @(posedge clk) disable iff (rst)
        sckRise && state_r == spfp_pkg::ST_SWR && bitCnt_r == 5'd7
        |=> bp_r == $past(rxNext[3:2]) && wen_r == $past(wen_r);
    endproperty
    a_stat_wr: assert property (p_stat_wr) else $error("status write wrong bits");

    property p_status_hi_zero;
        @(posedge clk) disable iff (rst) status[7:4] == 4'h0 && status[0] == (busyCnt_r != 0);
    endproperty
    a_status_hi_zero: assert property (p_status_hi_zero) else $error("status layout");

    property p_no_wrap;
        @(posedge clk) disable iff (rst)
        !EXTENDED && fetchOn_r && fifoInReady && rdPtr_r == 9'd255 |=> !fetchOn_r;
    endproperty
    a_no_wrap: assert property (p_no_wrap) else $error("basic read wrapped");
endmodule

`default_nettype wire

// file: tb/spfp_master_model.sv
// Serial bus master model that drives the flash port's serial pins.
// Assumes clk is the 40 MHz bench clock; one serial bit spans 8 clk (200 ns).
`default_nettype none

module spfp_master_model (
    // Clock
    input  wire logic clk,
    // Serial pins
    output logic      sck,
    output logic      chipSelectN,
    output logic      serialIn,
    input  wire logic serialOut,
    input  wire logic serialOutEn
);
    timeunit 1ns;
    timeprecision 100ps;

    logic soPin;

    // Released pin reads inverted, so a late enable shows up as bad data
    assign soPin = serialOutEn ? serialOut : ~serialOut;

    initial begin
        sck         = 1'b0;
        chipSelectN = 1'b1;
        serialIn    = 1'b0;
    end

    // Select edge with settle time; released data line toggles so it is never stale
    task automatic sel(input logic lvl);
        @(negedge clk);
        sck = 1'b0;
        repeat (4) @(negedge clk);
        chipSelectN = lvl;
        repeat (6) begin
            @(negedge clk);
            if (chipSelectN) serialIn = ~serialIn;
        end
    endtask

    // Master makes every clock edge; data goes out MSB first
    task automatic shift(input logic [63:0] d, input int n, output logic [63:0] q,
                         output logic oe);
        q  = '0;
        oe = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            sck      = 1'b0;
            serialIn = d[n-1-i];
            repeat (4) @(negedge clk);
            sck = 1'b1;
            q   = {q[62:0], soPin};
            oe  = oe | serialOutEn;
            repeat (3) @(negedge clk);
        end
    endtask
endmodule

`default_nettype wire

// file: tb/spi_slave_flash_port_tb_top.sv
// Self-checking bench for the serial flash port, extended and basic builds.
// Assumes the master model file is compiled first; cycle times are shortened.
`default_nettype none

module spi_slave_flash_port_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sck;
    logic        chipSelectN;
    logic        serialIn;
    logic        serialOut;
    logic        serialOutEn;
    logic        serialOutB;
    logic        serialOutEnB;
    logic        useB = 1'b0;
    int          nMismatch = 0;
    int          checked = 0;
    logic [31:0] seed = 32'h0683;
    logic [63:0] q;
    logic        oe;
    logic [15:0] d1;
    logic [15:0] d2;

    always #12.5 clk = ~clk;

    spfp_port #(.WRITE_CYC(200), .SECT_CYC(300), .FULL_CYC(400)) i_dut (
        .clk(clk), .rst(rst), .sck(sck), .chipSelectN(chipSelectN),
        .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn));

    // Basic build on the same pins; only the port under test answers the model
    spfp_port #(.EXTENDED(1'b0), .WRITE_CYC(200), .SECT_CYC(300), .FULL_CYC(400)) i_dut_b (
        .clk(clk), .rst(rst), .sck(sck), .chipSelectN(chipSelectN),
        .serialIn(serialIn), .serialOut(serialOutB), .serialOutEn(serialOutEnB));

    spfp_master_model i_m (
        .clk(clk), .sck(sck), .chipSelectN(chipSelectN), .serialIn(serialIn),
        .serialOut(useB ? serialOutB : serialOut),
        .serialOutEn(useB ? serialOutEnB : serialOutEn));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic final_report();
        if (nMismatch == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One framed transfer: n command bits, then m bits read back
    task automatic frame(input logic [63:0] d, input int n, input int m);
        logic [63:0] t;
        logic        o;
        i_m.sel(1'b0);
        i_m.shift(d, n, t, o);
        q  = '0;
        oe = 1'b0;
        if (m > 0) i_m.shift(64'h0, m, q, oe);
        i_m.sel(1'b1);
    endtask

    // Poll busy through status reads, bounded
    task automatic wait_idle();
        for (int k = 0; k < 30; k++) begin
            frame({56'h0, spfp_pkg::OPC_STAT_RD}, 8, 8);
            if (q[0] === 1'b0) return;
        end
        nMismatch++;
        final_report();
    endtask

    // Array write of one word, address upper seven bits random filler
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        frame({24'h0, spfp_pkg::OPC_ARR_WR, 7'(xs()), a, d}, 40, 0);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk("oeDeselected", {63'h0, serialOutEn}, 64'h0);
        frame({56'h0, spfp_pkg::OPC_STAT_RD}, 8, 16);
        chk("statusReset", q, 64'h0000);
        chk("statusOe", {63'h0, oe}, 64'h1);
        frame({48'h0, spfp_pkg::OPC_LATCH_SET, 8'hA7}, 16, 0);
        frame({56'h0, spfp_pkg::OPC_STAT_RD}, 8, 16);
        chk("statusPermit", q, 64'h0202);
        frame({56'h0, spfp_pkg::OPC_FULL_WIPE}, 8, 0);
        frame({56'h0, spfp_pkg::OPC_STAT_RD}, 8, 16);
        chk("statusBusy", q, 64'h0303);
        wait_idle();
        d1 = 16'(xs());
        d2 = 16'(xs());
        wr(9'd511, d1);
        wait_idle();
        wr(9'd0, d2);
        frame({40'h0, spfp_pkg::OPC_ARR_RD, 7'h55, 9'd0}, 24, 16);
        chk("readWhileBusy", {63'h0, oe}, 64'h0);
        wait_idle();
        frame({40'h0, spfp_pkg::OPC_ARR_RD, 7'(xs()), 9'd510}, 24, 48);
        chk("readWrap", q, {16'h0, 16'hFFFF, d1, d2});
        frame({40'h0, spfp_pkg::OPC_SECT_ERA, 7'(xs()), 9'h100}, 24, 0);
        wait_idle();
        frame({40'h0, spfp_pkg::OPC_ARR_RD, 7'(xs()), 9'd511}, 24, 32);
        chk("sectorErase", q, {32'h0, 16'hFFFF, d2});
        frame({56'h0, 8'hA5}, 8, 16);
        chk("badOpcodeOe", {63'h0, oe}, 64'h0);
        frame({48'h0, spfp_pkg::OPC_STAT_WR, 8'hFF}, 16, 0);
        frame({56'h0, spfp_pkg::OPC_STAT_RD}, 8, 16);
        chk("statusProtect", q, 64'h0E0E);
        wr(9'd3, 16'(xs()));
        frame({56'h0, spfp_pkg::OPC_STAT_RD}, 8, 8);
        chk("protectedSkip", q, 64'h0E);
        frame({56'h0, spfp_pkg::OPC_LATCH_CLR}, 8, 0);
        frame({56'h0, spfp_pkg::OPC_STAT_RD}, 8, 8);
        chk("statusClear", q, 64'h0C);
        // Basic build from here on; it saw every earlier frame as well
        useB = 1'b1;
        wait_idle();
        frame({48'h0, spfp_pkg::OPC_STAT_WR, 8'h00}, 16, 0);
        frame({56'h0, spfp_pkg::OPC_LATCH_SET}, 8, 0);
        frame({56'h0, spfp_pkg::OPC_FULL_WIPE}, 8, 0);
        wait_idle();
        d1 = 16'(xs());
        frame({40'h0, spfp_pkg::OPC_ARR_WR, 8'd255, d1[7:0]}, 24, 0);
        wait_idle();
        i_m.sel(1'b0);
        i_m.shift({48'h0, spfp_pkg::OPC_ARR_RD, 8'd254}, 16, q, oe);
        i_m.shift(64'h0, 16, q, oe);
        chk("basicRead", q, {48'h0, 8'hFF, d1[7:0]});
        i_m.shift(64'h0, 8, q, oe);
        chk("basicRelease", {63'h0, oe}, 64'h0);
        i_m.sel(1'b1);
        final_report();
    end

    initial begin
        repeat (100000) @(posedge clk);
        nMismatch++;
        final_report();
    end
endmodule

`default_nettype wire
